//--- erase_pkg.sv
// constants and types shared by the flash erase command engine
//
// Overview of operation
// - opcode 20h erases 4 kB block, A11..A0 ignored
// - opcode 52h erases 32 kB block, A14..A0 ignored
// - opcode D8h erases 64 kB block, A15..A0 ignored
// - write enable 06h must precede any erase
// - block frame: opcode then three address bytes
// - erase starts at chip select rise only
// - busy bit set while erase runs
// - write latch cleared before erase completes
// - opcode 25h drives busy bit onto SO
// - partial byte in block frame aborts, clears latch
// - fewer than three address bytes aborts, clears latch
// - protected block: no erase, clear latch, idle
// - 60h and C7h both mean chip erase
// - any protection refuses chip erase
// - chip frame is opcode only, erase at rise
// - partial byte in chip frame aborts, clears latch
// - suspend 75h ignored during chip erase
package erase_pkg;

	// ----------------------------------------
	// opcodes
	// ----------------------------------------
	localparam logic [7:0] OP_ERASE_4K = 8'h20;
	localparam logic [7:0] OP_ERASE_32K = 8'h52;
	localparam logic [7:0] OP_ERASE_64K = 8'hd8;
	localparam logic [7:0] OP_CHIP_ERASE_A = 8'h60;
	localparam logic [7:0] OP_CHIP_ERASE_B = 8'hc7;
	localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
	localparam logic [7:0] OP_ACTIVE_STATUS = 8'h25;
	localparam logic [7:0] OP_SUSPEND = 8'h75;

	// ----------------------------------------
	// frame shape and address masks
	// ----------------------------------------
	localparam logic [2:0] BLOCK_FRAME_BYTES = 3'h4;
	localparam logic [2:0] CHIP_FRAME_BYTES = 3'h1;
	localparam logic [2:0] ENABLE_FRAME_BYTES = 3'h1;
	localparam logic [23:0] MASK_4K = 24'hfff000;
	localparam logic [23:0] MASK_32K = 24'hff8000;
	localparam logic [23:0] MASK_64K = 24'hff0000;

	// ----------------------------------------
	// first status register fields
	// ----------------------------------------
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_LATCH_BIT = 1;
	localparam int STAT_RANGE_LSB = 2;
	localparam int STAT_RANGE_MSB = 4;
	localparam logic [7:0] STAT_RESET = 8'h00;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int BLOCK_ERASE_TIME_US = 100;
	localparam int WHOLE_ARRAY_ERASE_TIME_MS = 20;
	localparam int BLOCK_ERASE_CYCLES = BLOCK_ERASE_TIME_US * 1000 / CLK_PERIOD_NS;
	localparam int WHOLE_ARRAY_ERASE_CYCLES =
		WHOLE_ARRAY_ERASE_TIME_MS * 1000000 / CLK_PERIOD_NS;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [2:0] {
		ERASE_NONE,
		ERASE_4K,
		ERASE_32K,
		ERASE_64K,
		ERASE_CHIP
	} erase_kind_type;

	// one event from the serial front end
	typedef struct packed {
		logic byte_done;
		logic [7:0] data;
		logic [2:0] byte_index;
		logic frame_end;
		logic aligned;
		logic [2:0] byte_count;
	} spi_event_type;

endpackage

//--- spi_frame_shifter.sv
// serial front end: sck edge sampling, byte assembly and frame end
`timescale 1ns/1ns
module spi_frame_shifter
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic cs_n,
	input wire logic sck,
	input wire logic si,
	output erase_pkg::spi_event_type event_q
);

	logic sck_q;
	logic sck_d;
	logic cs_n_q;
	logic cs_n_d;
	logic [2:0] bit_cnt_q;
	logic [2:0] bit_cnt_d;
	logic [2:0] byte_cnt_q;
	logic [2:0] byte_cnt_d;
	logic [7:0] shift_q;
	logic [7:0] shift_d;
	erase_pkg::spi_event_type event_d;
	logic sck_rise;

	// ----------------------------------------
	// next state
	// ----------------------------------------
	// counters clear while deselected so every frame starts at bit 0
	always_comb
	begin
		sck_d = sck;
		cs_n_d = cs_n;
		sck_rise = sck & ~sck_q & ~cs_n;
		bit_cnt_d = bit_cnt_q;
		byte_cnt_d = byte_cnt_q;
		shift_d = shift_q;
		event_d = '0;
		if (cs_n)
		begin
			bit_cnt_d = 3'h0;
			byte_cnt_d = 3'h0;
		end
		else if (sck_rise)
		begin
			shift_d = {shift_q[6:0], si}; // msb first
			bit_cnt_d = bit_cnt_q + 3'h1;
			if (bit_cnt_q == 3'h7)
			begin
				event_d.byte_done = 1'b1;
				event_d.data = {shift_q[6:0], si};
				event_d.byte_index = byte_cnt_q;
				if (byte_cnt_q != 3'h7)
					byte_cnt_d = byte_cnt_q + 3'h1; // saturates, long frames stay long
			end
		end
		// rising chip select closes the frame
		if (cs_n && !cs_n_q)
		begin
			event_d.frame_end = 1'b1;
			event_d.aligned = (bit_cnt_q == 3'h0);
			event_d.byte_count = byte_cnt_q;
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sck_q <= 1'b0;
			cs_n_q <= 1'b1;
			bit_cnt_q <= 3'h0;
			byte_cnt_q <= 3'h0;
			shift_q <= 8'h00;
			event_q <= '0;
		end
		else
		begin
			sck_q <= sck_d;
			cs_n_q <= cs_n_d;
			bit_cnt_q <= bit_cnt_d;
			byte_cnt_q <= byte_cnt_d;
			shift_q <= shift_d;
			event_q <= event_d;
		end
	end

endmodule // spi_frame_shifter

//--- erase_timer.sv
// self-timed erase countdown
`timescale 1ns/1ns
module erase_timer
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic load,
	input wire logic [31:0] load_count,
	output logic busy_q,
	output logic done_q
);

	logic [31:0] count_q;
	logic [31:0] count_d;
	logic busy_d;
	logic done_d;

	// ----------------------------------------
	// countdown
	// ----------------------------------------
	// a load while busy is ignored; the engine never asks for one
	always_comb
	begin
		count_d = count_q;
		busy_d = busy_q;
		done_d = 1'b0;
		if (!busy_q && load)
		begin
			count_d = (load_count == 32'h0) ? 32'h1 : load_count;
			busy_d = 1'b1;
		end
		else if (busy_q)
		begin
			count_d = count_q - 32'h1;
			if (count_q == 32'h1)
			begin
				busy_d = 1'b0;
				done_d = 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			count_q <= 32'h0;
			busy_q <= 1'b0;
			done_q <= 1'b0;
		end
		else
		begin
			count_q <= count_d;
			busy_q <= busy_d;
			done_q <= done_d;
		end
	end

endmodule // erase_timer

//--- flash_erase_command_engine.sv
// erase command decode, checks and status for the serial flash
`timescale 1ns/1ns
module flash_erase_command_engine
#(
	parameter int BLOCK_CYCLES = erase_pkg::BLOCK_ERASE_CYCLES,
	parameter int CHIP_CYCLES = erase_pkg::WHOLE_ARRAY_ERASE_CYCLES
)
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic cs_n,
	input wire logic sck,
	input wire logic si,
	input wire logic [2:0] protect_range_field,
	input wire logic per_block_lock_select,
	input wire logic addressed_block_locked,
	input wire logic any_block_locked,
	output logic so,
	output logic so_oe,
	output logic [7:0] first_status_register,
	output logic write_latch_flag,
	output logic operation_in_progress_bit,
	output logic erase_start_q,
	output erase_pkg::erase_kind_type erase_kind_q,
	output logic [23:0] erase_addr_q
);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// opcode to erase kind; non-erase opcodes map to none
	function automatic erase_pkg::erase_kind_type decode_kind(input logic [7:0] op);
		case (op)
			erase_pkg::OP_ERASE_4K: decode_kind = erase_pkg::ERASE_4K;
			erase_pkg::OP_ERASE_32K: decode_kind = erase_pkg::ERASE_32K;
			erase_pkg::OP_ERASE_64K: decode_kind = erase_pkg::ERASE_64K;
			erase_pkg::OP_CHIP_ERASE_A,
			erase_pkg::OP_CHIP_ERASE_B: decode_kind = erase_pkg::ERASE_CHIP;
			default: decode_kind = erase_pkg::ERASE_NONE;
		endcase
	endfunction

	// block base: low address bits are don't care for each size
	// chip erase carries no address, so its base reads as zero
	function automatic logic [23:0] block_base(input erase_pkg::erase_kind_type kind,
		input logic [23:0] addr);
		case (kind)
			erase_pkg::ERASE_4K: block_base = addr & erase_pkg::MASK_4K;
			erase_pkg::ERASE_32K: block_base = addr & erase_pkg::MASK_32K;
			erase_pkg::ERASE_64K: block_base = addr & erase_pkg::MASK_64K;
			default: block_base = 24'h000000;
		endcase
	endfunction

	// ----------------------------------------
	// front end and timer
	// ----------------------------------------
	// byte and frame events from the shifter, timer handshake
	erase_pkg::spi_event_type ev;
	logic timer_busy;
	logic timer_done;
	logic timer_load;
	logic [31:0] timer_count;

	// shifter and timer share the one clock and reset
	spi_frame_shifter u_shifter
	(
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.cs_n(cs_n),
		.sck(sck),
		.si(si),
		.event_q(ev)
	);

	erase_timer u_timer
	(
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.load(timer_load),
		.load_count(timer_count),
		.busy_q(timer_busy),
		.done_q(timer_done)
	);

	// ----------------------------------------
	// command state
	// ----------------------------------------
	// phase of the current frame; an unknown phase ignores the rest
	typedef enum logic [1:0] {
		CMD_OPCODE,
		CMD_ADDRESS,
		CMD_STATUS,
		CMD_IGNORE
	} cmd_state_type;

	// frame registers; state and opcode reset at each frame end, address, latch and chip erase marker carry over
	cmd_state_type state_q;
	cmd_state_type state_d;
	logic [7:0] opcode_q;
	logic [7:0] opcode_d;
	logic [23:0] addr_q;
	logic [23:0] addr_d;
	logic latch_q;
	logic latch_d;
	logic chip_run_q;
	logic chip_run_d;
	// launch values and per-frame check results
	logic start_d;
	erase_pkg::erase_kind_type kind_d;
	logic [23:0] eaddr_d;
	erase_pkg::erase_kind_type frame_kind;
	logic frame_ok;
	logic frame_protected;

	// frame decode, checks and erase launch at chip select rise
	always_comb
	begin
		state_d = state_q;
		opcode_d = opcode_q;
		addr_d = addr_q;
		latch_d = latch_q;
		chip_run_d = chip_run_q;
		start_d = 1'b0;
		kind_d = erase_kind_q;
		eaddr_d = erase_addr_q;
		timer_load = 1'b0;
		timer_count = 32'h0;
		frame_kind = decode_kind(opcode_q);
		frame_ok = 1'b0;
		frame_protected = 1'b0;

		// byte collection inside a frame
		if (ev.byte_done)
		begin
			case (state_q)
				CMD_OPCODE:
				begin
					opcode_d = ev.data;
					// active status keeps so driven until chip select rises
					if (ev.data == erase_pkg::OP_ACTIVE_STATUS)
						state_d = CMD_STATUS;
					else if (decode_kind(ev.data) != erase_pkg::ERASE_NONE &&
						decode_kind(ev.data) != erase_pkg::ERASE_CHIP)
						state_d = CMD_ADDRESS;
					else
						state_d = CMD_IGNORE;
				end
				CMD_ADDRESS:
				begin
					addr_d = {addr_q[15:0], ev.data};
					// after the third address byte further bytes are only counted
					if (ev.byte_index == 3'h3)
						state_d = CMD_IGNORE;
				end
				CMD_STATUS: state_d = CMD_STATUS;
				CMD_IGNORE: state_d = CMD_IGNORE;
				default: state_d = CMD_IGNORE;
			endcase
		end

		// frame close
		// byte count saturates at seven, so over-long frames abort too
		if (ev.frame_end)
		begin
			state_d = CMD_OPCODE;
			opcode_d = 8'h00;
			if (timer_busy)
			begin
				// busy: everything ignored, suspend included during chip erase
				// a write enable sent now is lost; the host must wait for idle
				if (opcode_q == erase_pkg::OP_SUSPEND && chip_run_q)
					chip_run_d = 1'b1;
			end
			else if (opcode_q == erase_pkg::OP_WRITE_ENABLE)
			begin
				// a longer or split write enable frame leaves the latch alone
				if (ev.aligned && ev.byte_count == erase_pkg::ENABLE_FRAME_BYTES)
					latch_d = 1'b1;
			end
			else if (frame_kind != erase_pkg::ERASE_NONE)
			begin
				// without the latch the frame is dropped and nothing changes
				if (!latch_q)
				begin
					latch_d = 1'b0;
				end
				else
				begin
					if (frame_kind == erase_pkg::ERASE_CHIP)
					begin
						// opcode only, whole bytes, nothing protected anywhere
						frame_ok = ev.aligned &&
							ev.byte_count == erase_pkg::CHIP_FRAME_BYTES;
						frame_protected = (protect_range_field != 3'h0) ||
							(per_block_lock_select && any_block_locked);
					end
					else
					begin
						// opcode plus A[23:16], A[15:8] and A[7:0], whole bytes
						frame_ok = ev.aligned &&
							ev.byte_count == erase_pkg::BLOCK_FRAME_BYTES;
						frame_protected = (protect_range_field != 3'h0) ||
							(per_block_lock_select && addressed_block_locked);
					end
					// abort or refusal still drops the latch
					latch_d = 1'b0;
					// pulse, kind, masked base and timer load leave together
					if (frame_ok && !frame_protected)
					begin
						start_d = 1'b1;
						kind_d = frame_kind;
						eaddr_d = block_base(frame_kind, addr_q);
						timer_load = 1'b1;
						timer_count = (frame_kind == erase_pkg::ERASE_CHIP) ?
							32'(CHIP_CYCLES) : 32'(BLOCK_CYCLES);
						chip_run_d = (frame_kind == erase_pkg::ERASE_CHIP);
					end
				end
			end
		end

		// erase over: the chip erase marker drops one clock after busy
		if (timer_done)
			chip_run_d = 1'b0;
	end

	// command registers; reset loads constants only
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q <= CMD_OPCODE;
			opcode_q <= 8'h00;
			addr_q <= 24'h000000;
			latch_q <= 1'b0;
			chip_run_q <= 1'b0;
			erase_start_q <= 1'b0;
			erase_kind_q <= erase_pkg::ERASE_NONE;
			erase_addr_q <= 24'h000000;
		end
		else
		begin
			state_q <= state_d;
			opcode_q <= opcode_d;
			addr_q <= addr_d;
			latch_q <= latch_d;
			chip_run_q <= chip_run_d;
			erase_start_q <= start_d;
			erase_kind_q <= kind_d;
			erase_addr_q <= eaddr_d;
		end
	end

	// ----------------------------------------
	// status and active status output
	// ----------------------------------------
	logic so_q;
	logic so_d;
	logic so_oe_q;
	logic so_oe_d;

	// busy refreshed onto so every clock while active status is selected
	// so carries meaning only while so_oe is high
	always_comb
	begin
		so_oe_d = (state_q == CMD_STATUS) && !cs_n;
		so_d = timer_busy;
	end

	// registered so the pin never glitches between clocks
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			so_q <= 1'b0;
			so_oe_q <= 1'b0;
		end
		else
		begin
			so_q <= so_d;
			so_oe_q <= so_oe_d;
		end
	end

	// plain ports for the host-visible status
	assign so = so_q;
	assign so_oe = so_oe_q;
	assign write_latch_flag = latch_q;
	assign operation_in_progress_bit = timer_busy;

	// status image built from the busy and latch flops and the range input
	// bits 7:5 are unused and read as zero
	always_comb
	begin
		first_status_register = erase_pkg::STAT_RESET;
		first_status_register[erase_pkg::STAT_BUSY_BIT] = timer_busy;
		first_status_register[erase_pkg::STAT_LATCH_BIT] = latch_q;
		first_status_register[erase_pkg::STAT_RANGE_MSB:erase_pkg::STAT_RANGE_LSB] =
			protect_range_field;
	end

endmodule // flash_erase_command_engine

//--- erase_props.sv
// assertion checker for the flash erase command engine
`timescale 1ns/1ns
module erase_props
#(
	parameter int BLOCK_CYCLES = 20,
	parameter int CHIP_CYCLES = 100
)
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic cs_n,
	input wire logic [2:0] protect_range_field,
	input wire logic so,
	input wire logic so_oe,
	input wire logic [7:0] first_status_register,
	input wire logic write_latch_flag,
	input wire logic operation_in_progress_bit,
	input wire logic erase_start_q,
	input wire erase_pkg::erase_kind_type erase_kind_q,
	input wire logic [23:0] erase_addr_q
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	logic busy;
	logic [31:0] cnt_q, cnt_d, lim;
	assign busy = operation_in_progress_bit;
	assign lim = (erase_kind_q == erase_pkg::ERASE_CHIP) ? 32'(CHIP_CYCLES) : 32'(BLOCK_CYCLES);
	// busy cycles since launch; equals the loaded count when busy falls
	always_comb
	begin
		cnt_d = cnt_q;
		if (erase_start_q)
			cnt_d = 32'h1;
		else if (busy)
			cnt_d = cnt_q + 32'h1;
	end
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			cnt_q <= 32'h0;
		else
			cnt_q <= cnt_d;
	end
	sequence launch_s; erase_start_q; endsequence
	sequence cs_idle_s; cs_n [*3]; endsequence
	start_after_cs_a: assert property (launch_s |-> $past(cs_n, 2))
		else $error("launch without chip select rise");
	start_needs_latch_a: assert property (launch_s |-> $past(write_latch_flag))
		else $error("launch with latch clear");
	start_clears_latch_a: assert property (launch_s |-> !write_latch_flag)
		else $error("latch still set at launch");
	start_sets_busy_a: assert property (launch_s |-> busy)
		else $error("busy low at launch");
	busy_cause_a: assert property ($rose(busy) |-> erase_start_q)
		else $error("busy rose without launch");
	busy_length_a: assert property ($fell(busy) |-> cnt_q == lim)
		else $error("erase time wrong");
	mask_4k_a: assert property (launch_s ##0 erase_kind_q == erase_pkg::ERASE_4K
		|-> erase_addr_q[11:0] == 12'h0) else $error("4k base not aligned");
	mask_32k_a: assert property (launch_s ##0 erase_kind_q == erase_pkg::ERASE_32K
		|-> erase_addr_q[14:0] == 15'h0) else $error("32k base not aligned");
	mask_64k_a: assert property (launch_s ##0 erase_kind_q == erase_pkg::ERASE_64K
		|-> erase_addr_q[15:0] == 16'h0) else $error("64k base not aligned");
	status_map_a: assert property (first_status_register ==
		{3'h0, protect_range_field, write_latch_flag, busy}) else $error("status map");
	so_follows_a: assert property (so_oe |-> so == $past(busy))
		else $error("so not busy");
	so_release_a: assert property (cs_idle_s |-> !so_oe)
		else $error("so driven while deselected");
	start_pulse_a: assert property (launch_s |=> !erase_start_q)
		else $error("launch pulse too long");
endmodule // erase_props
bind flash_erase_command_engine erase_props #(.BLOCK_CYCLES(BLOCK_CYCLES),
	.CHIP_CYCLES(CHIP_CYCLES)) props (.ref_clk, .rst_n, .cs_n, .protect_range_field,
	.so, .so_oe, .first_status_register, .write_latch_flag, .operation_in_progress_bit,
	.erase_start_q, .erase_kind_q, .erase_addr_q);

//--- spi_host.sv
// serial host model framing opcodes and addresses onto the engine
`timescale 1ns/1ns
module spi_host
(
	input wire logic ref_clk,
	output logic cs_n,
	output logic sck,
	output logic si
);
	int half = 2;
	initial
	begin
		cs_n = 1'b1;
		sck = 1'b0;
		si = 1'b0;
	end
	// msb first from word[31]; sck idles low outside frames
	task automatic frame(input logic [31:0] word, input int nbits, input bit hold);
		int i;
		@(posedge ref_clk);
		cs_n <= 1'b0;
		for (i = 0; i < nbits; i++)
		begin
			@(posedge ref_clk);
			si <= word[31 - i];
			sck <= 1'b0;
			repeat (half) @(posedge ref_clk);
			sck <= 1'b1;
			repeat (half) @(posedge ref_clk);
		end
		sck <= 1'b0;
		if (!hold)
			release_cs();
	endtask
	// released data line flips so a stale bit is never mistaken for data
	task automatic release_cs();
		@(posedge ref_clk);
		cs_n <= 1'b1;
		si <= ~si;
		repeat (3) @(posedge ref_clk);
	endtask
endmodule // spi_host

//--- flash_erase_command_engine_tb.sv
// self-checking bench for the flash erase command engine
`timescale 1ns/1ns
module flash_erase_command_engine_tb;
	typedef struct packed
	{
		erase_pkg::erase_kind_type kind;
		logic [23:0] addr;
	} note_type;
	logic ref_clk, rst_n, cs_n, sck, si, lock_sel, blk_lock, any_lock, so, so_oe;
	logic write_latch_flag, busy, erase_start_q;
	logic [2:0] prot;
	logic [7:0] stat;
	logic [23:0] erase_addr_q;
	logic [31:0] r;
	erase_pkg::erase_kind_type erase_kind_q;
	note_type notes[$];
	note_type n;
	int failures = 0;
	int compares = 0;
	int i;
	int seed = 32'h574cc8e0;
	logic [7:0] ops[5] = '{erase_pkg::OP_ERASE_4K, erase_pkg::OP_ERASE_32K,
		erase_pkg::OP_ERASE_64K, erase_pkg::OP_CHIP_ERASE_A, erase_pkg::OP_CHIP_ERASE_B};
	erase_pkg::erase_kind_type kinds[5] = '{erase_pkg::ERASE_4K, erase_pkg::ERASE_32K,
		erase_pkg::ERASE_64K, erase_pkg::ERASE_CHIP, erase_pkg::ERASE_CHIP};
	logic [23:0] masks[5] = '{erase_pkg::MASK_4K, erase_pkg::MASK_32K, erase_pkg::MASK_64K,
		24'h0, 24'h0};
	spi_host host (.ref_clk(ref_clk), .cs_n(cs_n), .sck(sck), .si(si));
	flash_erase_command_engine #(.BLOCK_CYCLES(20), .CHIP_CYCLES(100)) dut (.ref_clk(ref_clk),
		.rst_n(rst_n), .cs_n(cs_n), .sck(sck), .si(si), .protect_range_field(prot),
		.per_block_lock_select(lock_sel), .addressed_block_locked(blk_lock),
		.any_block_locked(any_lock), .so(so), .so_oe(so_oe), .first_status_register(stat),
		.write_latch_flag(write_latch_flag), .operation_in_progress_bit(busy),
		.erase_start_q(erase_start_q), .erase_kind_q(erase_kind_q),
		.erase_addr_q(erase_addr_q));
	initial
	begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			failures++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// launches pop the oldest note; a launch with none pending is wrong
	always @(negedge ref_clk)
	begin
		if (erase_start_q === 1'b1)
		begin
			chk(32'(notes.size() > 0), 32'h1);
			if (notes.size() > 0)
			begin
				n = notes.pop_front();
				chk(32'(erase_kind_q), 32'(n.kind));
				if (n.kind != erase_pkg::ERASE_CHIP)
					chk({8'h0, erase_addr_q}, {8'h0, n.addr});
			end
		end
	end
	// write enable, then an erase frame of nbits; ok says it must launch
	task automatic erase(input int k, input int nbits, input bit ok);
		r = $random(seed);
		host.frame({erase_pkg::OP_WRITE_ENABLE, 24'h0}, 8, 1'b0);
		@(negedge ref_clk);
		chk(32'(write_latch_flag), 32'h1);
		if (ok)
			notes.push_back({kinds[k], r[23:0] & masks[k]});
		host.frame({ops[k], r[23:0]}, nbits, 1'b0);
		@(negedge ref_clk);
		chk(32'(write_latch_flag), 32'h0);
		chk(32'(busy), 32'(ok));
		chk({24'h0, stat}, {24'h0, 3'h0, prot, 1'b0, ok});
	endtask
	// poll the status busy bit under a bound
	task automatic wait_idle();
		for (i = 0; i < 400 && stat[0] !== 1'b0; i++)
			@(negedge ref_clk);
		if (i == 400)
		begin
			failures++;
			end_of_test();
		end
	endtask
	initial
	begin
		rst_n = 1'b0;
		prot = 3'h0;
		lock_sel = 1'b0;
		blk_lock = 1'b0;
		any_lock = 1'b0;
		repeat (8) @(posedge ref_clk);
		rst_n <= 1'b1;
		// all five erase codes; one block erase from a slow host
		for (int k = 0; k < 5; k++)
		begin
			host.half = (k == 1) ? 3 : 2;
			erase(k, (k < 3) ? 32 : 8, 1'b1);
			wait_idle();
		end
		// erase code with latch clear is dropped
		host.frame({erase_pkg::OP_ERASE_4K, 24'h123456}, 32, 1'b0);
		@(negedge ref_clk);
		chk(32'(busy), 32'h0);
		// aborts: split byte, short address, split chip byte, two-byte chip frame
		erase(0, 31, 1'b0);
		erase(2, 24, 1'b0);
		erase(3, 9, 1'b0);
		erase(4, 16, 1'b0);
		// protection by lock, by range and by any lock
		@(posedge ref_clk);
		lock_sel <= 1'b1;
		blk_lock <= 1'b1;
		erase(1, 32, 1'b0);
		@(posedge ref_clk);
		blk_lock <= 1'b0;
		prot <= 3'($random(seed)) | 3'h1;
		erase(4, 8, 1'b0);
		erase(0, 32, 1'b0);
		@(posedge ref_clk);
		prot <= 3'h0;
		any_lock <= 1'b1;
		erase(3, 8, 1'b0);
		@(posedge ref_clk);
		any_lock <= 1'b0;
		lock_sel <= 1'b0;
		// suspend during chip erase has no effect
		erase(3, 8, 1'b1);
		host.frame({erase_pkg::OP_SUSPEND, 24'h0}, 8, 1'b0);
		@(negedge ref_clk);
		chk(32'(busy), 32'h1);
		wait_idle();
		// active status on so until the erase ends
		erase(4, 8, 1'b1);
		host.frame({erase_pkg::OP_ACTIVE_STATUS, 24'h0}, 8, 1'b1);
		repeat (2) @(negedge ref_clk);
		chk({30'h0, so_oe, so}, 32'h3);
		for (i = 0; i < 400 && so !== 1'b0; i++)
			@(negedge ref_clk);
		if (i == 400)
		begin
			failures++;
			end_of_test();
		end
		chk(32'(busy), 32'h0);
		host.release_cs();
		@(negedge ref_clk);
		chk(32'(so_oe), 32'h0);
		chk(32'(notes.size()), 32'h0);
		end_of_test();
	end
endmodule // flash_erase_command_engine_tb
